// [pkg/iop_pkg.sv]
// Package with register map, reset values, field layouts and carrier types of the port and pulse-width block.
package iop_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IOP_IDX_PORT_A   = 6'h12;  // Port A data latch.
    localparam logic [5:0] IOP_IDX_DIR_A    = 6'h13;  // Port A direction.
    localparam logic [5:0] IOP_IDX_PORT_B   = 6'h14;  // Port B data latch.
    localparam logic [5:0] IOP_IDX_DIR_B    = 6'h15;  // Port B direction.
    localparam logic [5:0] IOP_IDX_PORT_C   = 6'h16;  // Port C data latch.
    localparam logic [5:0] IOP_IDX_DIR_C    = 6'h17;  // Port C direction.
    localparam logic [5:0] IOP_IDX_PORT_D   = 6'h18;  // Port D data latch.
    localparam logic [5:0] IOP_IDX_DIR_D    = 6'h19;  // Port D direction.
    localparam logic [5:0] IOP_IDX_DUTY0    = 6'h1a;  // Pulse width duty, channel 0.
    localparam logic [5:0] IOP_IDX_DUTY1    = 6'h1b;  // Pulse width duty, channel 1.
    localparam logic [5:0] IOP_IDX_OPTION   = 6'h1c;  // Pin sharing options and halt request.
    localparam logic [5:0] IOP_IDX_BITOP    = 6'h1d;  // Bit set, clear and complement command.
    localparam logic [5:0] IOP_IDX_STATUS   = 6'h1e;  // Live status, read only.

    // Option register fields.
    localparam int IOP_OPT_PFD       = 0;  // Divided-frequency output on the shared port A line.
    localparam int IOP_OPT_BUZZ      = 1;  // Buzzer on the true buzzer line.
    localparam int IOP_OPT_BUZZ_PAIR = 2;  // Complementary buzzer on the inverse line.
    localparam int IOP_OPT_PWM       = 3;  // Pulse width outputs on port D.
    localparam int IOP_OPT_MODE71    = 4;  // One selects (7+1) mode, zero selects (6+2).
    localparam int IOP_OPT_HALT      = 5;  // Write one to halt; reads the live halted state.
    localparam int IOP_OPT_W         = 5;  // Stored option bits, halt excluded.

    // Shared line positions.
    localparam int IOP_FREQ_OUT_SHARED_LINE = 3;  // Port A line carrying the divided frequency.
    localparam int IOP_BUZZER_TRUE_LINE     = 0;  // Port A line carrying the buzzer.
    localparam int IOP_BUZZER_INVERSE_LINE  = 1;  // Port A line carrying the inverse buzzer.
    localparam int IOP_PULSE_LINE_0         = 0;  // Port D line carrying channel 0.
    localparam int IOP_PULSE_LINE_1         = 1;  // Port D line carrying channel 1.

    // Bit command fields and codes.
    localparam logic [1:0] IOP_BITOP_SET   = 2'h1;  // Set the addressed bit.
    localparam logic [1:0] IOP_BITOP_CLEAR = 2'h2;  // Clear the addressed bit.
    localparam logic [1:0] IOP_BITOP_CPL   = 2'h3;  // Complement the whole port.

    // Reset values.
    localparam logic [7:0] IOP_DIR_RST   = 8'hff;  // Every line an input after reset.
    localparam logic [7:0] IOP_DATA_RST  = 8'h00;  // Output latches cleared.
    localparam logic [7:0] IOP_DUTY_RST  = 8'h00;  // Pulse outputs idle low.
    localparam logic [7:0] IOP_CNT_LAST  = 8'hff;  // Last count of a full pulse width cycle.

    // Classic Wishbone request from the master.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } iop_wb_req_s;

    // Four ports of eight lines each.
    typedef logic [3:0][7:0] iop_ports_t;

endpackage : iop_pkg

// [hdl/iop_ports.sv]
// Four bidirectional ports with shared divided-frequency, buzzer and pulse width outputs on Wishbone.
`timescale 1ns/1ps

// What this block does
// - Port data latches at indices 12h..18h.
// - Direction registers at indices 13h..19h.
// - Input reads sample the pad, no hold.
// - Output latch holds until rewritten.
// - Direction one is input, zero push-pull.
// - Read returns pad for inputs, latch otherwise.
// - Reset leaves every line an input.
// - Bit operations read, modify, write latch.
// - Port A lines wake device from halt.
// - Divided frequency gated by shared data bit.
// - Input mode ignores shared function options.
// - Divided frequency toggles on timer overflow.
// - Buzzer pair gated by true line's bit.
// - Pulse lines gated by their data bits.
// - Pulse reaches pad only in output mode.
// - Two duty registers at 1Ah, 1Bh.
// - (6+2): four modulation cycles of 64.
// - (6+2): bits 7..2 base, 1..0 extra.
// - (6+2): extra pulse when index below count.
// - (7+1): two modulation cycles of 128.
// - (7+1): bits 7..1 base, 0 extra.
// - (7+1): extra pulse when index below count.
module iop_ports
    import iop_pkg::*;
(
    input  wire logic        clk,       // System clock, 20 MHz.
    input  wire logic        rst,       // Asynchronous reset, active high.
    input  wire iop_wb_req_s wbReq,     // Wishbone request from the master.
    output logic             wbAck,     // Wishbone acknowledge.
    output logic [31:0]      wbDatOut,  // Wishbone read data.
    input  wire iop_ports_t  padIn,     // Pad levels of all four ports.
    output iop_ports_t       padOut,    // Driven pad levels.
    output iop_ports_t       padOeN,    // Output enable, low while driving.
    input  wire logic        timerOverflow,  // One-cycle pulse on timer/event counter overflow.
    input  wire logic        buzzerSource,   // Buzzer tone from the multi-function timer.
    output logic             halted,    // Device halted.
    output logic             wakeUp     // One-cycle pulse when port A ends a halt.
);

    // Whole state of the block in one packed record.
    typedef struct packed {
        iop_ports_t           data;      // Output latches.
        iop_ports_t           dir;       // Direction registers.
        iop_ports_t           drive;     // Registered pad output levels.
        logic [1:0][7:0]      dutyReg;   // Duty as written by software.
        logic [1:0][7:0]      dutyAct;   // Duty used by the running cycle.
        logic [7:0]           pwmCnt;    // Position inside the full pulse width cycle.
        logic [1:0]           pwmLine;   // Channel waveforms.
        logic                 pfdLevel;  // Divided-frequency waveform.
        logic [IOP_OPT_W-1:0] opt;       // Option bits.
        logic                 halted;    // Halted state.
        logic                 wakeUp;    // Wake-up pulse.
        logic [7:0]           paPrev;    // Previous port A pad sample for edge detection.
        logic                 ack;       // Bus acknowledge.
        logic [31:0]          rdat;      // Bus read data.
    } iop_state_s;

    iop_state_s st;       // Registered state.
    iop_state_s next_st;  // Next state.

    // Port view seen by a read: pad for input lines, latch for output lines.
    function automatic logic [7:0] portView(input logic [7:0] latch, input logic [7:0] dir,
                                            input logic [7:0] pad);
        portView = (dir & pad) | (~dir & latch);
    endfunction : portView

    // Duty count of the current modulation cycle for one channel.
    function automatic logic [7:0] dutyCount(input logic [7:0] duty, input logic mode71,
                                             input logic [7:0] cnt);
        logic [7:0] base;
        logic       extra;
        base  = 8'h00;
        extra = 1'b0;
        if (mode71) begin
            base  = {1'b0, duty[7:1]};
            extra = (cnt[7] < duty[0]);
        end else begin
            base  = {2'b00, duty[7:2]};
            extra = (cnt[7:6] < duty[1:0]);
        end
        dutyCount = base + {7'h00, extra};
    endfunction : dutyCount

    // Position inside the current modulation cycle.
    function automatic logic [7:0] subCount(input logic mode71, input logic [7:0] cnt);
        subCount = mode71 ? {1'b0, cnt[6:0]} : {2'b00, cnt[5:0]};
    endfunction : subCount

    // Decoded bus access, taken only on the first cycle of a strobe.
    logic       busReq;   // Access being answered now.
    logic       busWr;    // Write with the low byte lane enabled.
    logic [5:0] busIdx;   // Register index.
    logic [7:0] bitRes;   // Result of a bit command.
    logic       wakeEvt;  // Falling edge on a port A input line.

    assign busReq = wbReq.cyc & wbReq.stb & ~st.ack;
    assign busWr  = busReq & wbReq.we & wbReq.sel[0];
    assign busIdx = wbReq.adr[7:2];

    // Next state: bus slave, bit commands, shared pins, pulse width and wake-up.
    always_comb begin
        logic [1:0] bp;      // Port addressed by a bit command.
        logic [2:0] bb;      // Bit addressed by a bit command.
        logic [7:0] view;    // Port value read by a bit command.
        bp      = wbReq.dat[4:3];
        bb      = wbReq.dat[2:0];
        view    = portView(st.data[bp], st.dir[bp], padIn[bp]);
        next_st = st;
        bitRes  = view;

        // Bus answer: one acknowledge per strobe, dropped the next cycle.
        next_st.ack = busReq;
        next_st.rdat = 32'h0000_0000;  // Unmapped indices read zero.
        if (busReq && !wbReq.we) begin
            case (busIdx)
                IOP_IDX_PORT_A: next_st.rdat[7:0] = portView(st.data[0], st.dir[0], padIn[0]);
                IOP_IDX_PORT_B: next_st.rdat[7:0] = portView(st.data[1], st.dir[1], padIn[1]);
                IOP_IDX_PORT_C: next_st.rdat[7:0] = portView(st.data[2], st.dir[2], padIn[2]);
                IOP_IDX_PORT_D: next_st.rdat[7:0] = portView(st.data[3], st.dir[3], padIn[3]);
                IOP_IDX_DIR_A:  next_st.rdat[7:0] = st.dir[0];
                IOP_IDX_DIR_B:  next_st.rdat[7:0] = st.dir[1];
                IOP_IDX_DIR_C:  next_st.rdat[7:0] = st.dir[2];
                IOP_IDX_DIR_D:  next_st.rdat[7:0] = st.dir[3];
                IOP_IDX_DUTY0:  next_st.rdat[7:0] = st.dutyReg[0];
                IOP_IDX_DUTY1:  next_st.rdat[7:0] = st.dutyReg[1];
                IOP_IDX_OPTION: next_st.rdat[7:0] = {2'b00, st.halted, st.opt};
                IOP_IDX_STATUS: next_st.rdat[7:0] = {4'h0, st.pwmLine, st.pfdLevel, st.halted};
                default:        next_st.rdat = 32'h0000_0000;
            endcase
        end

        // Register writes; latches change only here or by a bit command.
        if (busWr) begin
            case (busIdx)
                IOP_IDX_PORT_A: next_st.data[0] = wbReq.dat[7:0];
                IOP_IDX_PORT_B: next_st.data[1] = wbReq.dat[7:0];
                IOP_IDX_PORT_C: next_st.data[2] = wbReq.dat[7:0];
                IOP_IDX_PORT_D: next_st.data[3] = wbReq.dat[7:0];
                IOP_IDX_DIR_A:  next_st.dir[0] = wbReq.dat[7:0];
                IOP_IDX_DIR_B:  next_st.dir[1] = wbReq.dat[7:0];
                IOP_IDX_DIR_C:  next_st.dir[2] = wbReq.dat[7:0];
                IOP_IDX_DIR_D:  next_st.dir[3] = wbReq.dat[7:0];
                IOP_IDX_DUTY0:  next_st.dutyReg[0] = wbReq.dat[7:0];
                IOP_IDX_DUTY1:  next_st.dutyReg[1] = wbReq.dat[7:0];
                IOP_IDX_OPTION: begin
                    next_st.opt = wbReq.dat[IOP_OPT_W-1:0];
                    if (wbReq.dat[IOP_OPT_HALT]) begin
                        next_st.halted = 1'b1;
                    end
                end
                IOP_IDX_BITOP: begin
                    // The whole port is read first, so input lines pick up their pad level.
                    case (wbReq.dat[6:5])
                        IOP_BITOP_SET:   bitRes[bb] = 1'b1;
                        IOP_BITOP_CLEAR: bitRes[bb] = 1'b0;
                        IOP_BITOP_CPL:   bitRes = ~view;
                        default:         bitRes = st.data[bp];
                    endcase
                    next_st.data[bp] = bitRes;
                end
                default: begin
                end
            endcase
        end

        // Divided frequency flips on every overflow, giving half the overflow rate.
        if (timerOverflow) begin
            next_st.pfdLevel = ~st.pfdLevel;
        end

        // Pulse width counter runs freely; duty is reloaded only at the cycle boundary.
        next_st.pwmCnt = st.pwmCnt + 8'h01;
        if (st.pwmCnt == IOP_CNT_LAST) begin
            next_st.dutyAct = st.dutyReg;
        end
        for (int ch = 0; ch < 2; ch++) begin
            next_st.pwmLine[ch] = subCount(st.opt[IOP_OPT_MODE71], st.pwmCnt) <
                                  dutyCount(st.dutyAct[ch], st.opt[IOP_OPT_MODE71], st.pwmCnt);
        end

        // Pad drive: plain latches, with the shared functions gated by their data bits.
        next_st.drive = st.data;
        if (st.opt[IOP_OPT_PFD]) begin
            next_st.drive[0][IOP_FREQ_OUT_SHARED_LINE] = st.data[0][IOP_FREQ_OUT_SHARED_LINE] & st.pfdLevel;
        end
        if (st.opt[IOP_OPT_BUZZ]) begin
            next_st.drive[0][IOP_BUZZER_TRUE_LINE] = st.data[0][IOP_BUZZER_TRUE_LINE] & buzzerSource;
            // The inverse line only pairs up while the true line is an output too.
            if (st.opt[IOP_OPT_BUZZ_PAIR] && !st.dir[0][IOP_BUZZER_TRUE_LINE]) begin
                next_st.drive[0][IOP_BUZZER_INVERSE_LINE] = st.data[0][IOP_BUZZER_TRUE_LINE] & ~buzzerSource;
            end
        end
        if (st.opt[IOP_OPT_PWM]) begin
            next_st.drive[3][IOP_PULSE_LINE_0] = st.data[3][IOP_PULSE_LINE_0] & st.pwmLine[0];
            next_st.drive[3][IOP_PULSE_LINE_1] = st.data[3][IOP_PULSE_LINE_1] & st.pwmLine[1];
        end

        // Wake-up on a falling edge of any port A input line; it beats a halt write in the same cycle only when already halted.
        next_st.paPrev = padIn[0];
        next_st.wakeUp = st.halted & wakeEvt;
        if (st.halted && wakeEvt) begin
            next_st.halted = 1'b0;
        end
    end

    // The previous sample resets to zero, so a line that is low coming out of reset cannot fake a falling edge.
    // Only input lines count; an output line that software drives low is not a wake source.
    assign wakeEvt = |(st.dir[0] & st.paPrev & ~padIn[0]);

    // State register; every line comes out of reset as an input.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st         <= '0;
            st.dir     <= {4{IOP_DIR_RST}};
            st.data    <= {4{IOP_DATA_RST}};
            st.dutyReg <= {2{IOP_DUTY_RST}};
            st.dutyAct <= {2{IOP_DUTY_RST}};
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register; the enable is the direction bit itself.
    assign wbAck    = st.ack;
    assign wbDatOut = st.rdat;
    assign padOut   = st.drive;
    assign padOeN   = st.dir;
    assign halted   = st.halted;
    assign wakeUp   = st.wakeUp;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Short pulse of one clock after a modulation cycle start.
    sequence onePulse0;
        st.pwmLine[0] ##1 !st.pwmLine[0];
    endsequence

    // A write to a data latch or bit command index with the low lane.
    logic dataWr;  // Write that may legally change a data latch.
    assign dataWr = busWr && (busIdx inside {IOP_IDX_PORT_A, IOP_IDX_PORT_B, IOP_IDX_PORT_C, IOP_IDX_PORT_D,
                                             IOP_IDX_BITOP});

    // Gating checks look one cycle ahead because the pad drive is registered.
    // Looking at the same cycle would compare against the previous option state.
    // A check holds even when its antecedent inputs change, since the drive is built from the sampled cycle.
    latch_hold_a: assert property (!dataWr |=> $stable(st.data))
        else $error("Output latch changed without a write.");
    read_view_a: assert property (busReq && !wbReq.we && busIdx == IOP_IDX_PORT_A |=>
        wbDatOut[7:0] == (($past(st.dir[0]) & $past(padIn[0])) | (~$past(st.dir[0]) & $past(st.data[0]))))
        else $error("Port read did not mix pad and latch.");
    pfd_toggle_a: assert property (timerOverflow |=> st.pfdLevel != $past(st.pfdLevel))
        else $error("Divided frequency did not toggle on overflow.");
    pfd_gate_a: assert property (st.opt[IOP_OPT_PFD] && !st.data[0][IOP_FREQ_OUT_SHARED_LINE] |=>
        !padOut[0][IOP_FREQ_OUT_SHARED_LINE])
        else $error("Divided frequency line not forced low.");
    pwm_gate_a: assert property (st.opt[IOP_OPT_PWM] && !st.data[3][IOP_PULSE_LINE_0] |=>
        !padOut[3][IOP_PULSE_LINE_0])
        else $error("Pulse line not forced low.");
    duty_reload_a: assert property (st.dutyAct != $past(st.dutyAct) |-> $past(st.pwmCnt) == IOP_CNT_LAST)
        else $error("Duty changed inside a running cycle.");
    pulse_62_a: assert property (!st.opt[IOP_OPT_MODE71] && st.pwmCnt[5:0] == 6'h00 &&
        st.dutyAct[0][7:2] == 6'h01 && st.pwmCnt[7:6] >= st.dutyAct[0][1:0] |=> onePulse0)
        else $error("Base duty of one in (6+2) not one clock wide.");
    pulse_71_a: assert property (st.opt[IOP_OPT_MODE71] && st.pwmCnt[6:0] == 7'h00 &&
        st.dutyAct[0] == 8'h01 && !st.pwmCnt[7] |=> onePulse0)
        else $error("Added pulse in (7+1) not one clock wide.");
    duty_zero_a: assert property (st.dutyAct[0] == 8'h00 && $stable(st.dutyAct[0]) |=> !st.pwmLine[0])
        else $error("Zero duty produced a high output.");
    wake_halt_a: assert property (st.halted && wakeEvt |=> !halted && wakeUp ##1 !wakeUp)
        else $error("Port A edge did not end the halt.");
    buzz_pair_a: assert property (st.opt[IOP_OPT_BUZZ] && st.opt[IOP_OPT_BUZZ_PAIR] && !st.dir[0][0] |=>
        padOut[0][IOP_BUZZER_INVERSE_LINE] == ($past(st.data[0][0]) & ~$past(buzzerSource)))
        else $error("Inverse buzzer line does not follow the true line.");
    bus_ack_a: assert property (busReq |=> wbAck ##1 !wbAck)
        else $error("Acknowledge not a single cycle.");

endmodule : iop_ports

// [tb/iop_pad_model.sv]
// Pad and board model that stands on the far side of the port lines.
`timescale 1ns/1ps
module iop_pad_model
    import iop_pkg::*;
(
    input  wire iop_ports_t padOut,    // Levels the block drives.
    input  wire iop_ports_t padOeN,    // Low while the block drives a line.
    input  wire iop_ports_t extLevel,  // Board level seen on undriven lines.
    output iop_ports_t      padIn      // Resolved wire level fed back.
);
    // A driven line shows the block's level, but a port read of an output line returns the latch instead.
    // An undriven line shows the board, which the bench sets high as a pull-high would.
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            for (int b = 0; b < 8; b++) begin
                padIn[p][b] = padOeN[p][b] ? extLevel[p][b] : padOut[p][b];
            end
        end
    end
endmodule : iop_pad_model

// [tb/io_ports_with_pwm_outputs_test.sv]
// Self-checking bench of the port and pulse width block.
`timescale 1ns/1ps
module io_ports_with_pwm_outputs_test;
    import iop_pkg::*;
    logic        clk, rst, tOvf, buzz, halted, wakeUp, wbAck;  // Clock, reset and side signals.
    iop_wb_req_s req;                                      // Bus request driven by the bench.
    logic [31:0] wbDatOut, seed;                           // Read data and random state.
    iop_ports_t  padIn, padOut, padOeN, ext;               // Pad wires and board levels.
    logic [7:0]  q, d, e;                                  // Scratch values.
    int          error_cnt, compares, cycCnt, hi;          // Counters.

    iop_ports i_iop_ports (.clk(clk), .rst(rst), .wbReq(req), .wbAck(wbAck), .wbDatOut(wbDatOut),
        .padIn(padIn), .padOut(padOut), .padOeN(padOeN), .timerOverflow(tOvf), .buzzerSource(buzz),
        .halted(halted), .wakeUp(wakeUp));
    iop_pad_model i_iop_pad_model (.padOut(padOut), .padOeN(padOeN), .extLevel(ext), .padIn(padIn));

    // Free running clock of 50 ns.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Repeatable pseudo random source.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Compare one byte and count it.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // One classic Wishbone cycle; read data is taken when ack is seen, then the request drops.
    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] dat, output logic [7:0] rd);
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h0, dat}};
        do @(posedge clk); while (wbAck !== 1'b1);
        rd = wbDatOut[7:0];
        req <= '0;
    endtask : wb

    // Verdict and end of run.
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // A hang counts as a mismatch; the whole run needs well under this many cycles.
    always @(posedge clk) begin
        cycCnt <= cycCnt + 1;
        if (cycCnt == 40000) begin
            error_cnt++;
            end_sim();
        end
    end

    initial begin
        rst = 1'b1; req = '0; tOvf = 1'b0; buzz = 1'b0; ext = '1;
        error_cnt = 0; compares = 0; cycCnt = 0; seed = 32'h6a156b76;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // Every line is an input after reset and duty reads zero.
        for (int p = 0; p < 4; p++) begin
            chk(padOeN[p], IOP_DIR_RST);
            wb(1'b0, IOP_IDX_DIR_A + 6'(2 * p), 8'h00, q);
            chk(q, 8'hff);
        end
        wb(1'b0, IOP_IDX_DUTY1, 8'h00, q);
        chk(q, IOP_DUTY_RST);
        // Outputs read the latch, inputs read the live pad.
        for (int p = 0; p < 4; p++) begin
            seed = lfsr(seed); d = seed[7:0]; e = seed[15:8];
            wb(1'b1, IOP_IDX_PORT_A + 6'(2 * p), d, q);
            wb(1'b1, IOP_IDX_DIR_A + 6'(2 * p), 8'h00, q);
            wb(1'b0, IOP_IDX_PORT_A + 6'(2 * p), 8'h00, q);
            chk(q, d);
            chk(padOut[p], d);
            wb(1'b1, IOP_IDX_DIR_A + 6'(2 * p), 8'hff, q);
            ext[p] <= e;
            wb(1'b0, IOP_IDX_PORT_A + 6'(2 * p), 8'h00, q);
            chk(q, e);
        end
        ext <= '1;
        wb(1'b0, 6'h3f, 8'h00, q);
        chk(q, 8'h00);
        // Bit set, clear and complement on port B driven with 0x0f.
        wb(1'b1, IOP_IDX_DIR_B, 8'h00, q);
        wb(1'b1, IOP_IDX_PORT_B, 8'h0f, q);
        wb(1'b1, IOP_IDX_BITOP, {1'b0, IOP_BITOP_SET, 2'd1, 3'd7}, q);
        wb(1'b1, IOP_IDX_BITOP, {1'b0, IOP_BITOP_CLEAR, 2'd1, 3'd0}, q);
        wb(1'b1, IOP_IDX_BITOP, {1'b0, IOP_BITOP_CPL, 2'd1, 3'd0}, q);
        wb(1'b0, IOP_IDX_PORT_B, 8'h00, q);
        chk(q, 8'h71);
        // Divided frequency on A3 and the buzzer pair on A0 and A1.
        wb(1'b1, IOP_IDX_OPTION, 8'h07, q);
        wb(1'b1, IOP_IDX_PORT_A, 8'h09, q);
        wb(1'b1, IOP_IDX_DIR_A, 8'hf4, q);
        repeat (3) @(negedge clk);
        d = padOut[0];
        for (int k = 0; k < 2; k++) begin
            tOvf <= 1'b1; buzz <= ~d[3];
            @(posedge clk) tOvf <= 1'b0;
            repeat (3) @(negedge clk);
            chk(padOut[0] & 8'h0b, {4'h0, ~d[3], 1'b0, d[3], ~d[3]});
            d = padOut[0];
        end
        wb(1'b1, IOP_IDX_PORT_A, 8'h00, q);
        repeat (3) @(negedge clk);
        chk(padOut[0] & 8'h0b, 8'h00);
        wb(1'b1, IOP_IDX_DIR_A, 8'hff, q);
        ext[0] <= 8'h5a;
        wb(1'b0, IOP_IDX_PORT_A, 8'h00, q);
        chk(q, 8'h5a);
        ext <= '1;
        // High clocks in a full cycle equal the duty value in both modes; D0 latch low forces zero.
        wb(1'b1, IOP_IDX_DIR_D, 8'hfc, q);
        for (int m = 0; m < 2; m++) begin
            for (int t = 0; t < 4; t++) begin
                seed = lfsr(seed);
                d = (t == 0) ? 8'h00 : (t == 1) ? 8'hff : (t == 2) ? 8'h01 : seed[7:0];
                wb(1'b1, IOP_IDX_OPTION, m ? 8'h18 : 8'h08, q);
                wb(1'b1, IOP_IDX_PORT_D, (t == 3) ? 8'h02 : 8'h03, q);
                wb(1'b1, IOP_IDX_DUTY0, d, q);
                wb(1'b1, IOP_IDX_DUTY1, ~d, q);
                repeat (600) @(posedge clk);
                for (int c = 0; c < 2; c++) begin
                    hi = 0;
                    repeat (256) @(negedge clk) hi += padOut[3][c];
                    chk(8'(hi), (c == 0) ? ((t == 3) ? 8'h00 : d) : ~d);
                end
            end
        end
        // Halt, then a falling port A input wakes the device.
        wb(1'b1, IOP_IDX_OPTION, 8'h20, q);
        @(negedge clk);
        chk({7'h0, halted}, 8'h01);
        ext[0] <= 8'hfe;
        hi = 0;
        repeat (5) @(negedge clk) hi += wakeUp;
        chk(8'(hi), 8'h01);
        chk({7'h0, halted}, 8'h00);
        end_sim();
    end
endmodule : io_ports_with_pwm_outputs_test
